// ### rtl/cpu_mode_address_vector_stack.sv
// Core mode unit: address shaping, vector address/format, indirect branch, stack widths
`timescale 1ns/1ns
module cpu_mode_address_vector_stack
  import cpu_mode_pkg::*;
(
  input  wire logic        mclk,          // Core clock
  input  wire logic        sys_rst,       // Synchronous reset, active high
  input  wire logic [1:0]  mode_sel,      // Requested operating mode, static
  input  wire logic        fetch32_sel,   // Requested 32-bit fetch width
  input  wire logic [31:0] data_ea,       // Raw data effective address
  input  wire logic [31:0] prog_ea,       // Raw program effective address
  input  wire logic [7:0]  vec_num,       // Exception vector number
  input  wire logic        vec_req,       // Pulse: fetch vector entry
  input  wire logic        ind_req,       // Pulse: memory indirect branch
  input  wire logic [7:0]  ind_addr,      // 8-bit absolute address from opcode
  output logic             mem_rd,        // Pulse: memory read request
  output logic      [31:0] mem_addr,      // Memory read address
  input  wire logic [31:0] mem_rdata,     // Memory read data
  input  wire logic        mem_rvalid,    // Pulse: read data valid
  input  wire logic [15:0] lower_half_register, // Address half register
  input  wire logic [15:0] upper_half_in, // Matching upper extended half
  input  wire logic        incdec_req,    // Pulse: pre/post inc or dec
  input  wire logic        incdec_down,   // 1 = decrement
  input  wire logic [2:0]  incdec_step,   // Step 1, 2 or 4
  input  wire logic        vbr_we,        // Load vector base
  input  wire logic        sbr_we,        // Load short address base
  input  wire logic        exr_we,        // Load extended control
  input  wire logic        ccr_we,        // Load condition code
  input  wire logic        mac_we,        // Load accumulate
  input  wire logic [63:0] wr_data,       // Control register write data
  output logic      [1:0]  mode,          // Latched operating mode
  output logic      [31:0] data_addr,     // Shaped data address
  output logic      [31:0] prog_addr,     // Shaped program address
  output logic             branch_valid,  // Pulse: branch target ready
  output logic      [31:0] branch_target, // Vector or indirect target
  output logic      [5:0]  pc_stack_width, // PC stack unit width in bits
  output logic      [2:0]  pc_stack_bytes, // PC stack bytes per push
  output logic             exr_stacked,   // Extended control stacked, maximum mode only
  output logic      [5:0]  fetch_width,   // Instruction fetch width
  output logic      [15:0] lower_half_out, // Updated lower half
  output logic      [15:0] upper_half_out, // Updated upper half
  output logic             upper_half_we, // Pulse: write upper half
  output logic      [31:0] pc,            // Program counter
  output logic      [7:0]  extended_control_reg,    // Extended control
  output logic      [7:0]  condition_code_reg,      // Condition code
  output logic      [31:0] vector_base_reg,         // Vector base
  output logic      [31:0] short_address_base_reg,  // Short address base
  output logic      [63:0] multiply_accumulate_reg  // Accumulate
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] shape_data(input cpu_mode_t m, input logic [31:0] a);
    case (m)
      MODE_NORMAL: shape_data = a & MASK_16;
      MODE_MIDDLE: shape_data = {8'h00, {8{a[15]}}, a[15:0]};
      default:     shape_data = a;
    endcase
  endfunction

  function automatic logic [31:0] shape_prog(input cpu_mode_t m, input logic [31:0] a);
    case (m)
      MODE_NORMAL:  shape_prog = a & MASK_16;
      MODE_MAXIMUM: shape_prog = a & PC_FETCH_MASK;
      default:      shape_prog = a & MASK_24 & PC_FETCH_MASK;
    endcase
  endfunction

  // Entry format of vectors and indirect operands is the same per mode
  function automatic logic [31:0] shape_target(input cpu_mode_t m, input logic [31:0] d);
    case (m)
      MODE_NORMAL:  shape_target = d & MASK_16;
      MODE_MAXIMUM: shape_target = d;
      default:      shape_target = d & MASK_24;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Mode latch
  // ------------------------------------------------------------
  cpu_mode_t cur_mode;
  cpu_mode_t next_mode;
  logic      fetch32;
  logic      next_fetch32;

  always_comb begin
    // Only advanced mode is built; other requests fall back to it
    next_mode    = cur_mode;
    next_fetch32 = fetch32;
    if (sys_rst) begin
      next_mode    = (cpu_mode_t'(mode_sel) == DEVICE_MODE) ? DEVICE_MODE
                                                            : DEVICE_MODE;
      next_fetch32 = DEVICE_FETCH32 | fetch32_sel;
    end
  end

  always_ff @(posedge mclk) begin
    cur_mode <= next_mode;
    fetch32  <= next_fetch32;
  end

  // ------------------------------------------------------------
  // Indirect and vector fetch sequencer
  // ------------------------------------------------------------
  ind_state_t  state;
  ind_state_t  next_state;
  logic        is_vec;
  logic        next_is_vec;
  logic [31:0] next_mem_addr;
  logic        next_mem_rd;
  logic        next_branch_valid;
  logic [31:0] next_branch_target;
  logic [31:0] vec_off;

  always_comb begin
    vec_off = (cur_mode == MODE_NORMAL) ? ({24'h0, vec_num} << VEC_SHIFT_16)
                                        : ({24'h0, vec_num} << VEC_SHIFT_32);
    next_state         = state;
    next_is_vec        = is_vec;
    next_mem_addr      = mem_addr;
    next_mem_rd        = 1'b0;
    next_branch_valid  = 1'b0;
    next_branch_target = branch_target;
    case (state)
      IND_IDLE: begin
        if (vec_req) begin
          next_mem_addr = VECTOR_BASE_ZERO + vec_off;
          next_mem_rd   = 1'b1;
          next_is_vec   = 1'b1;
          next_state    = IND_WAIT;
        end else if (ind_req) begin
          next_mem_addr = {24'h0, ind_addr};
          next_mem_rd   = 1'b1;
          next_is_vec   = 1'b0;
          next_state    = IND_WAIT;
        end
      end
      IND_WAIT: begin
        if (mem_rvalid) begin
          next_branch_target = shape_target(cur_mode, mem_rdata);
          next_state         = IND_DONE;
        end
      end
      IND_DONE: begin
        next_branch_valid = 1'b1;
        next_state        = IND_IDLE;
      end
      default: next_state = IND_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state         <= IND_IDLE;
      is_vec        <= 1'b0;
      mem_addr      <= 32'h0;
      mem_rd        <= 1'b0;
      branch_valid  <= 1'b0;
      branch_target <= 32'h0;
    end else begin
      state         <= next_state;
      is_vec        <= next_is_vec;
      mem_addr      <= next_mem_addr;
      mem_rd        <= next_mem_rd;
      branch_valid  <= next_branch_valid;
      branch_target <= next_branch_target;
    end
  end

  // ------------------------------------------------------------
  // Address shaping, stack and fetch widths
  // ------------------------------------------------------------
  logic [31:0] next_data_addr;
  logic [31:0] next_prog_addr;
  logic [5:0]  next_stack_width;
  logic [2:0]  next_stack_bytes;
  logic        next_exr_stacked;
  logic [5:0]  next_fetch_width;
  logic [31:0] next_pc;

  always_comb begin
    next_data_addr   = shape_data(cur_mode, data_ea);
    next_prog_addr   = shape_prog(cur_mode, prog_ea);
    next_exr_stacked = 1'b0;
    // Fetch width never reaches the data path
    next_fetch_width = fetch32 ? FETCH_WIDTH_32 : FETCH_WIDTH_16;
    next_pc          = (branch_valid) ? branch_target : pc;
    case (cur_mode)
      MODE_NORMAL: begin
        next_stack_width = STACK_WIDTH_16;
        next_stack_bytes = STACK_BYTES_16;
      end
      MODE_MAXIMUM: begin
        next_stack_width = STACK_WIDTH_32;
        next_stack_bytes = STACK_BYTES_32;
        next_exr_stacked = 1'b1;
      end
      default: begin
        next_stack_width = STACK_WIDTH_24;
        next_stack_bytes = STACK_BYTES_24;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      data_addr      <= 32'h0;
      prog_addr      <= 32'h0;
      pc_stack_width <= STACK_WIDTH_24;
      pc_stack_bytes <= STACK_BYTES_24;
      exr_stacked    <= 1'b0;
      fetch_width    <= FETCH_WIDTH_32;
      pc             <= 32'h0;
      mode           <= DEVICE_MODE;
    end else begin
      data_addr      <= next_data_addr;
      prog_addr      <= next_prog_addr;
      pc_stack_width <= next_stack_width;
      pc_stack_bytes <= next_stack_bytes;
      exr_stacked    <= next_exr_stacked;
      fetch_width    <= next_fetch_width;
      pc             <= next_pc & PC_FETCH_MASK;
      mode           <= cur_mode;
    end
  end

  // ------------------------------------------------------------
  // Increment/decrement carry into upper half
  // ------------------------------------------------------------
  logic [16:0] sum;
  logic [15:0] next_lower;
  logic [15:0] next_upper;
  logic        next_upper_we;
  logic        carry_mode;

  always_comb begin
    // Normal and middle: carry ripples into the upper half
    carry_mode = (cur_mode == MODE_NORMAL) || (cur_mode == MODE_MIDDLE);
    sum = incdec_down ? ({1'b0, lower_half_register} - {14'h0, incdec_step})
                      : ({1'b0, lower_half_register} + {14'h0, incdec_step});
    next_lower    = sum[15:0];
    next_upper    = upper_half_in;
    next_upper_we = 1'b0;
    if (incdec_req) begin
      if (carry_mode && sum[16]) begin
        next_upper    = incdec_down ? upper_half_in - 16'h1 : upper_half_in + 16'h1;
        next_upper_we = 1'b1;
      end else if (!carry_mode) begin
        // Full 32-bit register: upper half is the top segment
        next_upper    = {upper_half_in} + (sum[16] ? (incdec_down ? 16'hffff : 16'h1)
                                                   : 16'h0);
        next_upper_we = sum[16];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lower_half_out <= 16'h0;
      upper_half_out <= 16'h0;
      upper_half_we  <= 1'b0;
    end else begin
      lower_half_out <= next_lower;
      upper_half_out <= next_upper;
      upper_half_we  <= next_upper_we;
    end
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  ctrl_reg_file u_ctrl (
    .mclk                    (mclk),
    .sys_rst                 (sys_rst),
    .vbr_we                  (vbr_we),
    .sbr_we                  (sbr_we),
    .exr_we                  (exr_we),
    .ccr_we                  (ccr_we),
    .mac_we                  (mac_we),
    .exc_entry               (vec_req),
    .wr_data                 (wr_data),
    .vector_base_reg         (vector_base_reg),
    .short_address_base_reg  (short_address_base_reg),
    .extended_control_reg    (extended_control_reg),
    .condition_code_reg      (condition_code_reg),
    .multiply_accumulate_reg (multiply_accumulate_reg)
  );

endmodule

// ### rtl/cpu_mode_pkg.sv
// Package: operating modes, address widths, vector and stack formats for the core mode unit
// Function
// - Normal mode: 64 kbyte space, only lower 16 effective address bits valid.
// - Normal mode: vector table at zero, one 16-bit branch address per entry.
// - Normal mode: PC pushed and popped on the stack as 16-bit units.
// - Normal/middle: increment carry or borrow on lower half updates upper half.
// - Middle mode: 16 Mbyte total, 16 Mbyte program area, 64 kbyte data area.
// - Middle mode: lower 16 data address bits used, upper eight sign-extended.
// - Middle/advanced: 32-bit vector entries, top byte ignored, lower 24 bits used.
// - Middle/advanced: indirect branch operand is longword with top byte taken as zero.
// - Indirect jump or call reads memory at 8-bit address, then branches to the address read there.
// - Middle/advanced: PC pushed and popped as 24-bit units.
// - Advanced: linear 4 Gbyte space, 16 Mbyte program area, full data area.
// - Advanced/maximum: vector table at zero, one 32-bit entry per vector.
// - Advanced/maximum: upper halves act as 16-bit or upper 32-bit segments.
// - Maximum: indirect branch operand is longword, all 32 bits used.
// - Maximum: PC stacked in 32-bit units, extended control register always stacked.
// - Fetch width 16 or 32 bits; affects instruction fetch only, never data.
// - This device always fetches instructions 32 bits wide.
// - Control registers: 32 PC, 8 extended, 8 condition, 32 bases, 64 accumulate.
// - Normal mode is not selectable on this device.
// - Only advanced mode runs on this device; others are not offered.
package cpu_mode_pkg;

  typedef enum logic [1:0] {
    MODE_NORMAL   = 2'b00,
    MODE_MIDDLE   = 2'b01,
    MODE_ADVANCED = 2'b10,
    MODE_MAXIMUM  = 2'b11
  } cpu_mode_t;

  typedef enum logic [1:0] {
    IND_IDLE = 2'b00,
    IND_READ = 2'b01,
    IND_WAIT = 2'b10,
    IND_DONE = 2'b11
  } ind_state_t;

  localparam logic [31:0] VECTOR_BASE_ZERO   = 32'h0000_0000;
  localparam logic [31:0] VBR_RESET          = 32'h0000_0000;
  localparam logic [31:0] SBR_RESET          = 32'hffff_ff00;
  localparam logic [31:0] VBR_VALID_MASK     = 32'hffff_f000;
  localparam logic [31:0] SBR_VALID_MASK     = 32'hffff_ff00;
  localparam logic [31:0] PC_FETCH_MASK      = 32'hffff_fffe;
  localparam logic [7:0]  EXR_RESET          = 8'h7f;
  localparam logic [7:0]  EXR_RSVD_ONES      = 8'h78;
  localparam logic [7:0]  CCR_RESET          = 8'h80;
  localparam logic [31:0] MASK_16            = 32'h0000_ffff;
  localparam logic [31:0] MASK_24            = 32'h00ff_ffff;
  localparam logic [31:0] MASK_32            = 32'hffff_ffff;
  localparam logic [2:0]  VEC_SHIFT_16       = 3'h1;
  localparam logic [2:0]  VEC_SHIFT_32       = 3'h2;
  localparam logic [2:0]  STACK_BYTES_16     = 3'h2;
  localparam logic [2:0]  STACK_BYTES_24     = 3'h4;
  localparam logic [2:0]  STACK_BYTES_32     = 3'h4;
  localparam logic [5:0]  STACK_WIDTH_16     = 6'h10;
  localparam logic [5:0]  STACK_WIDTH_24     = 6'h18;
  localparam logic [5:0]  STACK_WIDTH_32     = 6'h20;
  localparam logic [5:0]  FETCH_WIDTH_16     = 6'h10;
  localparam logic [5:0]  FETCH_WIDTH_32     = 6'h20;
  localparam cpu_mode_t   DEVICE_MODE        = MODE_ADVANCED;
  localparam logic        DEVICE_FETCH32     = 1'b1;

endpackage

// ### rtl/ctrl_reg_file.sv
// Control register file: vector base, short address base, extended control, condition, accumulate
`timescale 1ns/1ns
module ctrl_reg_file
  import cpu_mode_pkg::*;
(
  input  wire logic        mclk,       // Core clock
  input  wire logic        sys_rst,    // Synchronous reset, active high
  input  wire logic        vbr_we,     // Load vector base
  input  wire logic        sbr_we,     // Load short address base
  input  wire logic        exr_we,     // Load extended control
  input  wire logic        ccr_we,     // Load condition code
  input  wire logic        mac_we,     // Load accumulate
  input  wire logic        exc_entry,  // Exception entry sets masks
  input  wire logic [63:0] wr_data,    // Write data
  output logic      [31:0] vector_base_reg,         // Vector base
  output logic      [31:0] short_address_base_reg,  // Short address base
  output logic      [7:0]  extended_control_reg,    // Extended control
  output logic      [7:0]  condition_code_reg,      // Condition code
  output logic      [63:0] multiply_accumulate_reg  // Accumulate
);

  logic [31:0] next_vbr;
  logic [31:0] next_sbr;
  logic [7:0]  next_exr;
  logic [7:0]  next_ccr;
  logic [63:0] next_mac;

  always_comb begin
    next_vbr = vbr_we ? (wr_data[31:0] & VBR_VALID_MASK) : vector_base_reg;
    next_sbr = sbr_we ? (wr_data[31:0] & SBR_VALID_MASK) : short_address_base_reg;
    next_exr = exr_we ? (wr_data[7:0] | EXR_RSVD_ONES) : extended_control_reg;
    next_ccr = ccr_we ? wr_data[7:0] : condition_code_reg;
    next_mac = mac_we ? wr_data : multiply_accumulate_reg;
    if (exc_entry) begin
      // Exception entry: interrupt masks forced high, trace off
      next_ccr = next_ccr | CCR_RESET;
      next_exr = EXR_RESET;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      vector_base_reg         <= VBR_RESET;
      short_address_base_reg  <= SBR_RESET;
      extended_control_reg    <= EXR_RESET;
      condition_code_reg      <= CCR_RESET;
      multiply_accumulate_reg <= 64'h0;
    end else begin
      vector_base_reg         <= next_vbr;
      short_address_base_reg  <= next_sbr;
      extended_control_reg    <= next_exr;
      condition_code_reg      <= next_ccr;
      multiply_accumulate_reg <= next_mac;
    end
  end

endmodule

// ### tb/cpu_mode_address_vector_stack_chk.sv
// Port-level assertions for the core mode unit
`timescale 1ns/1ns
module cpu_mode_address_vector_stack_chk
  import cpu_mode_pkg::*;
(
  input wire logic        mclk, sys_rst,                // Clock, reset
  input wire logic [31:0] data_ea, prog_ea, data_addr, prog_addr, // Addresses
  input wire logic [7:0]  vec_num, ind_addr,            // Request operands
  input wire logic        vec_req, ind_req, mem_rd, mem_rvalid, branch_valid, // Strobes
  input wire logic [31:0] mem_addr, mem_rdata, branch_target, pc, // Branch path
  input wire logic [15:0] lower_half_register, upper_half_in, upper_half_out, // Halves
  input wire logic        incdec_req, incdec_down, upper_half_we, exr_stacked, // Controls
  input wire logic [2:0]  incdec_step, pc_stack_bytes,  // Step, stack bytes
  input wire logic [1:0]  mode,                         // Latched mode
  input wire logic [5:0]  pc_stack_width, fetch_width   // Widths
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence s_ind_take; ind_req && !vec_req; endsequence
  sequence s_vec_take; vec_req; endsequence
  sequence s_carry;
    incdec_req && !incdec_down && ({1'b0, lower_half_register} + incdec_step > 17'h0ffff);
  endsequence
  sequence s_borrow; incdec_req && incdec_down && (lower_half_register < incdec_step); endsequence
  property p_mode; mode == MODE_ADVANCED; endproperty
  property p_stack;
    pc_stack_width == STACK_WIDTH_24 && pc_stack_bytes == STACK_BYTES_24 && !exr_stacked;
  endproperty
  property p_fetch; fetch_width == FETCH_WIDTH_32; endproperty
  property p_addr;
    !$past(sys_rst) |-> data_addr == $past(data_ea) && prog_addr == ($past(prog_ea) & 32'h00ff_fffe);
  endproperty
  property p_ind_addr; s_ind_take ##1 mem_rd |-> mem_addr == {24'h0, $past(ind_addr)}; endproperty
  property p_vec_addr; s_vec_take ##1 mem_rd |-> mem_addr == {22'h0, $past(vec_num), 2'h0}; endproperty
  property p_answer; mem_rvalid |-> ##2 branch_valid; endproperty
  property p_target; mem_rvalid ##2 branch_valid |-> branch_target == ($past(mem_rdata, 2) & MASK_24); endproperty
  property p_pc; branch_valid |=> pc == (branch_target & PC_FETCH_MASK); endproperty
  property p_carry; s_carry |=> upper_half_we && upper_half_out == $past(upper_half_in) + 16'h1; endproperty
  property p_borrow; s_borrow |=> upper_half_we && upper_half_out == $past(upper_half_in) - 16'h1; endproperty
  property p_rd_pulse; mem_rd |=> !mem_rd; endproperty
  a_mode: assert property (p_mode) else $error("mode not advanced");
  a_stack: assert property (p_stack) else $error("stack unit wrong");
  a_fetch: assert property (p_fetch) else $error("fetch width wrong");
  a_addr: assert property (p_addr) else $error("address shaping wrong");
  a_ind_addr: assert property (p_ind_addr) else $error("indirect address wrong");
  a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong");
  a_answer: assert property (p_answer) else $error("branch late");
  a_target: assert property (p_target) else $error("target wrong");
  a_pc: assert property (p_pc) else $error("pc load wrong");
  a_carry: assert property (p_carry) else $error("carry not applied");
  a_borrow: assert property (p_borrow) else $error("borrow not applied");
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
endmodule
bind cpu_mode_address_vector_stack cpu_mode_address_vector_stack_chk u_chk (.*);

// ### tb/mem_model.sv
// Behavioural system memory answering vector and indirect branch reads
`timescale 1ns/1ns
module mem_model (
  input  wire logic        mclk,       // Core clock
  input  wire logic        sys_rst,    // Synchronous reset
  input  wire logic [3:0]  dly,        // Extra answer cycles
  input  wire logic        mem_rd,     // Read request
  input  wire logic [31:0] mem_addr,   // Read address
  output logic      [31:0] mem_rdata,  // Read data
  output logic             mem_rvalid  // Read data valid
);
  logic [31:0] addr;
  logic [3:0]  cnt;
  logic        busy;

  // Idle data toggles so a stale word is never mistaken for an answer
  always @(posedge mclk) begin
    mem_rvalid <= 1'b0;
    mem_rdata  <= ~mem_rdata;
    if (sys_rst) begin
      busy      <= 1'b0;
      mem_rdata <= 32'h0;
    end else if (mem_rd) begin
      busy <= 1'b1;
      addr <= mem_addr;
      cnt  <= dly;
    end else if (busy && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (busy) begin
      busy       <= 1'b0;
      mem_rvalid <= 1'b1;
      mem_rdata  <= addr ^ 32'hc35a_0f12; // dirty top byte on purpose
    end
  end
endmodule

// ### tb/test_cpu_mode_address_vector_stack.sv
// Self-checking testbench for the core mode unit with a memory model
`timescale 1ns/1ns
module test_cpu_mode_address_vector_stack;
  import cpu_mode_pkg::*;
  logic        mclk, sys_rst, fetch32_sel, vec_req, ind_req, mem_rd, mem_rvalid;
  logic        incdec_req, incdec_down, vbr_we, sbr_we, exr_we, ccr_we, mac_we;
  logic        branch_valid, exr_stacked, upper_half_we;
  logic [1:0]  mode_sel, mode;
  logic [2:0]  incdec_step, pc_stack_bytes;
  logic [3:0]  dly;
  logic [5:0]  pc_stack_width, fetch_width;
  logic [7:0]  vec_num, ind_addr, extended_control_reg, condition_code_reg;
  logic [15:0] lower_half_register, upper_half_in, lower_half_out, upper_half_out;
  logic [31:0] data_ea, prog_ea, mem_addr, mem_rdata, data_addr, prog_addr, branch_target, pc;
  logic [31:0] vector_base_reg, short_address_base_reg;
  logic [63:0] wr_data, multiply_accumulate_reg;
  int          fails, check_count;

  cpu_mode_address_vector_stack u_dut (.*);
  mem_model u_mem (.mclk(mclk), .sys_rst(sys_rst), .dly(dly), .mem_rd(mem_rd),
                   .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));

  always #5 mclk = ~mclk;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wait_for(input bit on_branch);
    int i;
    for (i = 0; i < 40; i++) begin
      if (on_branch ? branch_valid === 1'b1 : mem_rd === 1'b1) break;
      tick(1);
    end
    cmp(on_branch ? "branch_valid wait" : "mem_rd wait", 1'b1, i < 40);
    if (i == 40) finish_test();
  endtask

  task automatic do_reset(input logic [1:0] m);
    @(posedge mclk);
    sys_rst  <= 1'b1;
    mode_sel <= m;
    tick(19);
    @(posedge mclk);
    sys_rst <= 1'b0;
    tick(1);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_static;
    cmp("mode", MODE_ADVANCED, mode);
    cmp("pc_stack_width", 6'h18, pc_stack_width);
    cmp("pc_stack_bytes", 3'h4, pc_stack_bytes);
    cmp("exr_stacked", 1'b0, exr_stacked);
    cmp("fetch_width", 6'h20, fetch_width);
    cmp("vector_base_reg", 32'h0, vector_base_reg);
    cmp("short_address_base_reg", 32'hffff_ff00, short_address_base_reg);
    cmp("extended_control_reg", 8'h7f, extended_control_reg);
    cmp("condition_code_reg", 8'h80, condition_code_reg);
    cmp("multiply_accumulate_reg", 64'h0, multiply_accumulate_reg);
  endtask

  // Mode and fetch requests change mid-run and must be ignored
  task automatic t_addr;
    @(posedge mclk);
    mode_sel    <= 2'b01;
    fetch32_sel <= 1'b0;
    data_ea     <= 32'hfedc_8001;
    prog_ea     <= 32'h89ab_cdef;
    tick(2);
    cmp("data_addr", 32'hfedc_8001, data_addr);
    cmp("prog_addr", 32'h00ab_cdee, prog_addr);
    cmp("mode", MODE_ADVANCED, mode);
    cmp("fetch_width", 6'h20, fetch_width);
  endtask

  // Indirect request rides along with every vector request, which must win
  task automatic t_branch(input bit is_vec, input logic [7:0] n, input logic [3:0] d);
    logic [31:0] a;
    a = is_vec ? {22'h0, n, 2'h0} : {24'h0, n};
    @(posedge mclk);
    dly      <= d;
    vec_req  <= is_vec;
    ind_req  <= 1'b1;
    vec_num  <= n;
    ind_addr <= is_vec ? ~n : n;
    @(posedge mclk);
    vec_req <= 1'b0;
    ind_req <= 1'b0;
    #1;
    wait_for(1'b0);
    cmp("mem_addr", a, mem_addr);
    wait_for(1'b1);
    cmp("branch_target", (a ^ 32'hc35a_0f12) & 32'h00ff_ffff, branch_target);
    tick(1);
    cmp("pc", (a ^ 32'hc35a_0f12) & 32'h00ff_fffe, pc);
  endtask

  task automatic t_incdec(input logic [15:0] lo, input logic [15:0] up, input logic down,
                          input logic [2:0] st, input logic we, input logic [15:0] exp_up);
    @(posedge mclk);
    lower_half_register <= lo;
    upper_half_in       <= up;
    incdec_down         <= down;
    incdec_step         <= st;
    incdec_req          <= 1'b1;
    @(posedge mclk);
    incdec_req <= 1'b0;
    #1;
    cmp("upper_half_we", we, upper_half_we);
    // Sum wraps at 16 bits, as the lower half does
    cmp("lower_half_out", 16'(down ? lo - st : lo + st), lower_half_out);
    cmp("upper_half_out", exp_up, upper_half_out);
  endtask

  task automatic t_wr(input int sel, input logic [63:0] d, input logic [63:0] exp);
    logic [63:0] got;
    @(posedge mclk);
    wr_data <= d;
    {mac_we, ccr_we, exr_we, sbr_we, vbr_we} <= 5'h1 << sel;
    @(posedge mclk);
    {mac_we, ccr_we, exr_we, sbr_we, vbr_we} <= 5'h0;
    #1;
    case (sel)
      0: got = vector_base_reg;
      1: got = short_address_base_reg;
      2: got = extended_control_reg;
      3: got = condition_code_reg;
      default: got = multiply_accumulate_reg;
    endcase
    cmp($sformatf("control register %0d", sel), exp, got);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    {mode_sel, fetch32_sel, dly, vec_num, ind_addr} = 23'h1;
    {vec_req, ind_req, incdec_req, incdec_down, incdec_step} = 7'h0;
    {vbr_we, sbr_we, exr_we, ccr_we, mac_we, wr_data} = 69'h0;
    {data_ea, prog_ea, lower_half_register, upper_half_in} = 96'h0;
    fails = 0;
    check_count = 0;
    do_reset(2'b00);
    t_static();
    t_addr();
    t_branch(1'b0, 8'h00, 4'h0);
    t_branch(1'b0, 8'hff, 4'h7);
    t_branch(1'b1, 8'h00, 4'h0);
    t_branch(1'b1, 8'hff, 4'h3);
    t_incdec(16'hffff, 16'h1234, 1'b0, 3'h1, 1'b1, 16'h1235);
    t_incdec(16'hfffe, 16'hffff, 1'b0, 3'h4, 1'b1, 16'h0000);
    t_incdec(16'h0001, 16'h0000, 1'b1, 3'h2, 1'b1, 16'hffff);
    t_incdec(16'hfffb, 16'h0001, 1'b0, 3'h4, 1'b0, 16'h0001);
    t_incdec(16'h8000, 16'h7777, 1'b1, 3'h4, 1'b0, 16'h7777);
    t_wr(0, 64'hffff_ffff_ffff_ffff, 64'hffff_f000);
    t_wr(1, 64'hffff_ffff_ffff_ffff, 64'hffff_ff00);
    t_wr(2, 64'h0, 64'h78);
    t_wr(3, 64'h5a, 64'h5a);
    t_wr(4, 64'hffff_ffff_8765_4321, 64'hffff_ffff_8765_4321);
    do_reset(2'b11);
    t_static();
    finish_test();
  end
endmodule
